// ===== hdl/mr_pkg.sv
// package for the move and return instruction executor
// assumes a 14-bit instruction word and a 13-bit program counter
`default_nettype none
package mr_pkg;

    // ==========================================================
    // widths
    localparam int INSTR_W = 14;
    localparam int PC_W = 13;
    localparam int DATA_W = 8;
    localparam int FILE_ADDR_W = 7;
    localparam int FILE_DEPTH = 128;

    // ==========================================================
    // field positions
    localparam int LIT_LSB = 0;
    localparam int FILE_LSB = 0;
    localparam int OP7_LSB = 7;
    localparam int OP6_LSB = 8;

    // ==========================================================
    // encodings chosen for this executor
    localparam logic [13:0] ENC_NOP = 14'h0000;
    localparam logic [13:0] ENC_RETURN = 14'h0008;
    localparam logic [13:0] ENC_RETURN_INT = 14'h0009;
    localparam logic [6:0] OP_MOVE_TO_FILE = 7'h01;
    localparam logic [5:0] OP_LOAD_LITERAL = 6'h30;
    localparam logic [5:0] OP_RETURN_LITERAL = 6'h34;

    // ==========================================================
    // reset values and cycle counts
    localparam logic [12:0] PC_RESET = 13'h0000;
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic GIE_RESET = 1'b0;
    localparam int RETURN_CYCLES = 2;

    typedef enum logic [0:0] {
        ST_EXECUTE,
        ST_RETURN_FLUSH
    } mr_state_type;

endpackage
`default_nettype wire

// ===== hdl/mr_file_mem.sv
// data file register memory, one write port and one read port
// read data come out of a register one cycle after the address
`timescale 1ns/1ps
`default_nettype none
module mr_file_mem
    import mr_pkg::*;
#(
    parameter int WIDTH = DATA_W,
    parameter int DEPTH = FILE_DEPTH,
    parameter int ADDR_W = FILE_ADDR_W
) (
    // clock
    input wire logic i_ref_clk,
    // write port
    input wire logic i_wr_en,
    input wire logic [ADDR_W-1:0] i_wr_addr,
    input wire logic [WIDTH-1:0] i_wr_data,
    // read port
    input wire logic [ADDR_W-1:0] i_rd_addr,
    output logic [WIDTH-1:0] o_rd_data
);

    logic [WIDTH-1:0] mem [DEPTH];

    // no reset on the array so it maps onto block memory
    always_ff @(posedge i_ref_clk) begin
        if (i_wr_en) begin
            mem[i_wr_addr] <= i_wr_data;
        end
        o_rd_data <= mem[i_rd_addr];
    end

endmodule
`default_nettype wire

// ===== hdl/mr_exec.sv
// executor for the move, literal load, no-operation and return instructions
// assumes one instruction cycle per clock and an external stack
// that shows its top entry on i_top_of_stack and pops on o_stack_pop
`timescale 1ns/1ps
`default_nettype none
module mr_exec
    import mr_pkg::*;
(
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_reset_n,
    // instruction fetch
    input wire logic [INSTR_W-1:0] i_instr,
    input wire logic i_instr_valid,
    output logic o_instr_ready,
    // stack
    input wire logic [PC_W-1:0] i_top_of_stack,
    output logic o_stack_pop,
    // interrupt control
    input wire logic i_gie_clear,
    output logic o_global_interrupt_enable,
    // file register read
    input wire logic [FILE_ADDR_W-1:0] i_file_rd_addr,
    output logic [DATA_W-1:0] o_file_rd_data,
    // core state
    output logic [PC_W-1:0] o_pc,
    output logic [DATA_W-1:0] o_accumulator,
    output logic o_unknown_instr
);

    // ==========================================================
    // decode
    logic accept;
    logic is_nop;
    logic is_move;
    logic is_load;
    logic is_ret_lit;
    logic is_return;
    logic is_ret_int;
    logic is_any_return;
    logic [DATA_W-1:0] literal;
    logic [FILE_ADDR_W-1:0] file_addr;

    assign accept = i_instr_valid && o_instr_ready;
    assign literal = i_instr[LIT_LSB +: DATA_W];
    assign file_addr = i_instr[FILE_LSB +: FILE_ADDR_W];
    assign is_nop = (i_instr == ENC_NOP);
    assign is_return = (i_instr == ENC_RETURN);
    assign is_ret_int = (i_instr == ENC_RETURN_INT);
    assign is_move = (i_instr[OP7_LSB +: 7] == OP_MOVE_TO_FILE);
    assign is_load = (i_instr[OP6_LSB +: 6] == OP_LOAD_LITERAL);
    assign is_ret_lit = (i_instr[OP6_LSB +: 6] == OP_RETURN_LITERAL);
    assign is_any_return = is_return || is_ret_int || is_ret_lit;

    // ==========================================================
    // sequencing state
    mr_state_type state;
    mr_state_type next_state;
    logic [PC_W-1:0] next_pc;
    logic [DATA_W-1:0] next_accumulator;
    logic next_gie;
    logic next_unknown;

    // a return spends its second cycle as a flush, so fetch is held off
    assign o_instr_ready = (state == ST_EXECUTE);
    assign o_stack_pop = accept && is_any_return;

    always_comb begin
        next_state = state;
        next_pc = o_pc;
        next_accumulator = o_accumulator;
        next_gie = o_global_interrupt_enable;
        next_unknown = 1'b0;
        unique case (state)
            ST_EXECUTE: begin
                if (accept) begin
                    if (is_any_return) begin
                        next_pc = i_top_of_stack;
                        next_state = ST_RETURN_FLUSH;
                    end else begin
                        next_pc = PC_W'(o_pc + 1'b1);
                    end
                    if (is_load || is_ret_lit) begin
                        next_accumulator = literal;
                    end
                    if (!(is_nop || is_move || is_load || is_any_return)) begin
                        next_unknown = 1'b1;
                    end
                end
            end
            ST_RETURN_FLUSH: begin
                next_state = ST_EXECUTE;
            end
        endcase
        // the set from a return from interrupt wins over a clear in the same cycle
        if (accept && is_ret_int) begin
            next_gie = 1'b1;
        end else if (i_gie_clear) begin
            next_gie = 1'b0;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state <= ST_EXECUTE;
            o_pc <= PC_RESET;
            o_accumulator <= ACC_RESET;
            o_global_interrupt_enable <= GIE_RESET;
            o_unknown_instr <= 1'b0;
        end else begin
            state <= next_state;
            o_pc <= next_pc;
            o_accumulator <= next_accumulator;
            o_global_interrupt_enable <= next_gie;
            o_unknown_instr <= next_unknown;
        end
    end

    // ==========================================================
    // data file registers
    logic file_wr_en;

    assign file_wr_en = accept && is_move;

    mr_file_mem #(
        .WIDTH(DATA_W),
        .DEPTH(FILE_DEPTH),
        .ADDR_W(FILE_ADDR_W)
    ) u_file_mem (
        .i_ref_clk(i_ref_clk),
        .i_wr_en(file_wr_en),
        .i_wr_addr(file_addr),
        .i_wr_data(o_accumulator),
        .i_rd_addr(i_file_rd_addr),
        .o_rd_data(o_file_rd_data)
    );

    // ==========================================================
    // assertions
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_reset_n);

    property p_move_to_file;
        (accept && is_move) |->
            file_wr_en ##1 $stable(o_accumulator) && o_instr_ready
            && (o_pc == PC_W'($past(o_pc) + 1'b1));
    endproperty
    a_move_to_file: assert property (p_move_to_file)
        else $error("move to file did not write or took more than one cycle");

    property p_load_literal;
        (accept && is_load) |=> (o_accumulator == $past(literal)) && o_instr_ready
            && (o_pc == PC_W'($past(o_pc) + 1'b1));
    endproperty
    a_load_literal: assert property (p_load_literal)
        else $error("load literal did not reach the accumulator in one cycle");

    property p_return_int_pc;
        (accept && is_ret_int) |-> o_stack_pop ##1
            (o_pc == $past(i_top_of_stack)) && !o_instr_ready && !o_stack_pop
            ##1 o_instr_ready && (o_pc == $past(o_pc));
    endproperty
    a_return_int_pc: assert property (p_return_int_pc)
        else $error("return from interrupt did not pop into the counter in two cycles");

    property p_return_int_gie;
        (accept && is_ret_int) |=> o_global_interrupt_enable;
    endproperty
    a_return_int_gie: assert property (p_return_int_gie)
        else $error("return from interrupt left interrupts disabled");

    property p_return_literal;
        (accept && is_ret_lit) |=> (o_accumulator == $past(literal))
            && (o_pc == $past(i_top_of_stack)) && !o_instr_ready ##1 o_instr_ready;
    endproperty
    a_return_literal: assert property (p_return_literal)
        else $error("return with literal lost its operand or its target");

    property p_return_sub;
        (accept && is_return) |-> o_stack_pop ##1
            (o_pc == $past(i_top_of_stack)) && $stable(o_accumulator)
            && !o_instr_ready ##1 o_instr_ready;
    endproperty
    a_return_sub: assert property (p_return_sub)
        else $error("subroutine return did not take two cycles");

    property p_nop;
        (accept && is_nop && !i_gie_clear) |=> $stable(o_accumulator)
            && $stable(o_global_interrupt_enable) && o_instr_ready
            && (o_pc == PC_W'($past(o_pc) + 1'b1));
    endproperty
    a_nop: assert property (p_nop)
        else $error("no-operation changed state beyond the counter");

    property p_gie_set_wins;
        (accept && is_ret_int && i_gie_clear) |=> o_global_interrupt_enable;
    endproperty
    a_gie_set_wins: assert property (p_gie_set_wins)
        else $error("interrupt enable clear beat the set");

    property p_flush_no_pop;
        !o_instr_ready |-> !o_stack_pop && !file_wr_en
            ##1 $stable(o_pc) && $stable(o_accumulator);
    endproperty
    a_flush_no_pop: assert property (p_flush_no_pop)
        else $error("stack popped, file written or state moved during a flush cycle");

    c_return_int: cover property (accept && is_ret_int ##2 accept);
    c_return_literal: cover property (accept && is_ret_lit);
    c_move_then_load: cover property (accept && is_move ##1 accept && is_load);
    c_gie_race: cover property (accept && is_ret_int && i_gie_clear);

endmodule
`default_nettype wire

// ===== dv/mr_prog_mem_model.sv
// program memory model: queues words from the bench and offers them in order
// assumes the executor takes a word at an edge where valid and ready are high
`timescale 1ns/1ps
`default_nettype none
module mr_prog_mem_model
    import mr_pkg::*;
(
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_reset_n,
    // loading from the bench
    input wire logic i_push,
    input wire logic [INSTR_W-1:0] i_word,
    // instruction port
    input wire logic i_ready,
    output logic [INSTR_W-1:0] o_instr,
    output logic o_valid
);
    logic [INSTR_W-1:0] fifo[$];
    logic [INSTR_W-1:0] junk;
    // ==========================================================
    // word held until taken; an idle bus shows a toggling pattern
    always @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            fifo.delete();
            junk = 14'h2AAA;
            o_valid <= 1'b0;
            o_instr <= junk;
        end else begin
            if (o_valid && i_ready) begin
                void'(fifo.pop_front());
            end
            if (i_push) begin
                fifo.push_back(i_word);
            end
            junk = ~junk;
            o_valid <= (fifo.size() != 0);
            o_instr <= (fifo.size() != 0) ? fifo[0] : junk;
        end
    end
endmodule
`default_nettype wire

// ===== dv/testbench.sv
// self-checking bench for the move and return executor
// assumes the program memory model and the executor share one clock
`timescale 1ns/1ps
`default_nettype none
module testbench
    import mr_pkg::*;
;
    logic clk = 0, rst_n = 0, push = 0, gie_clr = 0, valid, ready, pop, global_interrupt_enable, unk;
    logic [13:0] word = 0, instr;
    logic [12:0] top_of_stack = 0, pc, exp_pc;
    logic [7:0] acc, rd_data, exp_acc, exp_rd, mem[FILE_DEPTH];
    logic [6:0] rd_addr = 0;
    logic exp_gie, exp_rdy, exp_unk, exp_pop, taken, rd_known = 0, run = 0;
    bit written[FILE_DEPTH];
    int err_total = 0, tests_run = 0, cycles = 0, seed = 32'hEA42;
    logic [13:0] corner[11] = '{{OP_LOAD_LITERAL, 8'hFF}, {OP_MOVE_TO_FILE, 7'h7F},
        {OP_LOAD_LITERAL, 8'h00}, {OP_MOVE_TO_FILE, 7'h00}, ENC_RETURN, ENC_RETURN,
        ENC_RETURN_INT, {OP_RETURN_LITERAL, 8'hFF}, ENC_NOP, 14'h3FFF, 14'h305A};

    mr_prog_mem_model pmem (.i_ref_clk(clk), .i_reset_n(rst_n), .i_push(push),
        .i_word(word), .i_ready(ready), .o_instr(instr), .o_valid(valid));
    mr_exec uut (.i_ref_clk(clk), .i_reset_n(rst_n), .i_instr(instr), .i_instr_valid(valid),
        .o_instr_ready(ready), .i_top_of_stack(top_of_stack), .o_stack_pop(pop), .i_gie_clear(gie_clr),
        .o_global_interrupt_enable(global_interrupt_enable), .i_file_rd_addr(rd_addr), .o_file_rd_data(rd_data),
        .o_pc(pc), .o_accumulator(acc), .o_unknown_instr(unk));

    initial begin
        forever #10 clk = ~clk;
    end

    // ==========================================================
    // helpers
    function automatic logic [13:0] make_word(input int kind, input logic [7:0] v);
        case (kind)
            0: return ENC_NOP;
            1: return ENC_RETURN;
            2: return ENC_RETURN_INT;
            3: return {OP_MOVE_TO_FILE, v[6:0]};
            4: return {OP_LOAD_LITERAL, v};
            5: return {OP_RETURN_LITERAL, v};
            default: return {6'h3F, v};
        endcase
    endfunction

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic check_hs(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR t=%0t handshake got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic check_rd(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR t=%0t read got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic drive(input logic p, input logic [13:0] w, input logic fixed);
        int r;
        @(posedge clk);
        #1;
        r = $random(seed);
        push = p;
        word = w;
        gie_clr = (r[2:0] == 3'h0);
        top_of_stack = r[20:8];
        rd_addr = fixed ? 7'h7F : r[27:21];
    endtask

    task automatic complete_run;
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // ==========================================================
    // reference model, sampled mid-cycle where everything has settled
    always @(negedge clk) begin
        if (run) begin
            exp_pop = valid && exp_rdy && (instr == ENC_RETURN || instr == ENC_RETURN_INT ||
                instr[13:8] == OP_RETURN_LITERAL);
            taken = valid && exp_rdy;
            check(pc, exp_pc);
            check(acc, exp_acc);
            check(global_interrupt_enable, exp_gie);
            check_hs(ready, exp_rdy);
            check_hs(pop, exp_pop);
            check(unk, exp_unk);
            if (rd_known) begin
                check_rd(rd_data, exp_rd);
            end
            exp_rd = mem[rd_addr];
            rd_known = written[rd_addr] && !(taken && instr[13:7] == OP_MOVE_TO_FILE &&
                instr[6:0] == rd_addr);
            exp_unk = 0;
            if (taken) begin
                exp_pc = exp_pop ? top_of_stack : exp_pc + 13'h0001;
                if (instr[13:7] == OP_MOVE_TO_FILE) begin
                    mem[instr[6:0]] = exp_acc;
                    written[instr[6:0]] = 1;
                end else if (instr[13:8] == OP_LOAD_LITERAL ||
                             instr[13:8] == OP_RETURN_LITERAL) begin
                    exp_acc = instr[7:0];
                end else if (instr != ENC_NOP && !exp_pop) begin
                    exp_unk = 1;
                end
            end
            if (taken && instr == ENC_RETURN_INT) exp_gie = 1;
            else if (gie_clr) exp_gie = 0;
            exp_rdy = !exp_pop;
        end
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            err_total++;
            complete_run();
        end
    end

    // ==========================================================
    // main sequence
    initial begin
        exp_pc = PC_RESET;
        exp_acc = ACC_RESET;
        exp_gie = GIE_RESET;
        exp_unk = 0;
        exp_rdy = 1;
        repeat (3) @(posedge clk);
        #1;
        rst_n = 1;
        run = 1;
        foreach (corner[i]) drive(1'b1, corner[i], 1'b1);
        $display("corner sequence done");
        repeat (400) drive(($random(seed) & 3) != 0, make_word({$random(seed)} % 7,
            8'($random(seed))), 1'b0);
        drive(1'b0, 14'h0000, 1'b0);
        for (int n = 0; n < 1000 && valid; n++) drive(1'b0, 14'h0000, 1'b0);
        repeat (3) drive(1'b0, 14'h0000, 1'b0);
        $display("random sequence done");
        complete_run();
    end
endmodule
`default_nettype wire
